// *** common/iwt_pkg.sv ***
package iwt_pkg;
    // Register indices; byte addresses are index times four, so all are multiples of four
    localparam logic [7:0] IWT_IDX_TIMEOUT = 8'h00;
    localparam logic [7:0] IWT_IDX_MASK = 8'h01;
    localparam logic [7:0] IWT_IDX_STATE = 8'h02;
    localparam logic [7:0] IWT_IDX_IRQ_STATUS = 8'h04;
    localparam logic [7:0] IWT_IDX_IRQ_MASK = 8'h05;
    localparam logic [11:0] IWT_ADDR_TIMEOUT = {2'h0, IWT_IDX_TIMEOUT, 2'h0};
    localparam logic [11:0] IWT_ADDR_MASK = {2'h0, IWT_IDX_MASK, 2'h0};
    localparam logic [11:0] IWT_ADDR_STATE = {2'h0, IWT_IDX_STATE, 2'h0};
    localparam logic [11:0] IWT_ADDR_IRQ_STATUS = {2'h0, IWT_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] IWT_ADDR_IRQ_MASK = {2'h0, IWT_IDX_IRQ_MASK, 2'h0};

    // Field positions
    localparam int IWT_MASK_KEYBOARD_BIT = 0;
    localparam int IWT_MASK_MOUSE_BIT = 1;
    localparam int IWT_MASK_SER1_BIT = 2;
    localparam int IWT_MASK_SER2_BIT = 3;
    localparam int IWT_NUM_SOURCES = 4;
    localparam int IWT_STATE_EXPIRY_BIT = 0;
    localparam int IWT_STATE_UNIT_LO_BIT = 2;
    localparam int IWT_STATE_UNIT_HI_BIT = 7;
    localparam int IWT_IRQ_EXPIRED_BIT = 0;
    localparam int IWT_IRQ_TRIGGER_BIT = 1;

    // Reset values
    localparam logic [7:0] IWT_TIMEOUT_RESET = 8'h00;
    localparam logic [3:0] IWT_MASK_RESET = 4'h0;
    localparam logic [7:0] IWT_STATE_RESET = 8'h01;
    localparam logic [1:0] IWT_IRQ_RESET = 2'h0;

    // Timing
    localparam longint IWT_CLOCK_HZ = 25000000;
    localparam longint IWT_SECOND_NS = 1000000000;
    localparam longint IWT_CLOCK_PERIOD_NS = IWT_SECOND_NS / IWT_CLOCK_HZ;
    localparam longint IWT_CYCLES_PER_SECOND = IWT_SECOND_NS / IWT_CLOCK_PERIOD_NS;
    localparam int IWT_SECONDS_PER_MINUTE = 60;

    typedef enum logic {
        IWT_IDLE,
        IWT_COUNTING
    } iwt_state_t;
endpackage

// *** sim/iwt_event_source.sv ***
`timescale 1ns/100ps
`default_nettype none
module iwt_event_source (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] fireReq,
    output logic [3:0] srcLevel
);
    // Each request line stays up three cycles so that the two-flop sync always sees it
    logic [1:0] hold [4];
    always_ff @(posedge clock or negedge rst_n) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_n) begin
                hold[i] <= 2'h0;
            end else if (fireReq[i]) begin
                hold[i] <= 2'h3;
            end else if (hold[i] != 2'h0) begin
                hold[i] <= hold[i] - 2'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            srcLevel[i] = (hold[i] != 2'h0);
        end
    end
endmodule
`default_nettype wire

// *** sim/iwt_watchdog_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module iwt_watchdog_props
    import iwt_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic expiry_output_n,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic takeEdge;
    logic timeoutWrite;
    assign takeEdge = psel && penable && !pready;
    assign timeoutWrite = takeEdge && pwrite && (paddr == IWT_ADDR_TIMEOUT);
    ////////////////////////////////////////////////////////////////////////
    AST_ONE_WAIT: assert property (takeEdge |=> pready) else $error("pready not one cycle after take");
    AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    AST_READY_IDLE: assert property (!(psel && penable) |=> !pready) else $error("pready without access");
    AST_RDATA_QUIET: assert property (!pready |-> prdata == 32'h0) else $error("prdata nonzero outside answer");
    AST_RDATA_UPPER: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_WRITE_RELEASE: assert property (timeoutWrite |=> expiry_output_n)
        else $error("expiry output not released by timeout write");
    AST_ZERO_IDLE: assert property (timeoutWrite && pwdata[7:0] == 8'h00 |=> expiry_output_n [*8])
        else $error("expiry after zero timeout");
    AST_EXPIRY_STICKY: assert property (!expiry_output_n && !timeoutWrite |=> !expiry_output_n)
        else $error("expiry released without timeout write");
    ////////////////////////////////////////////////////////////////////////
    COV_SLVERR: cover property (pslverr);
    COV_EXPIRY: cover property ($fell(expiry_output_n));
    COV_IRQ: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import iwt_pkg::*;
    localparam int CPS = 10;
    localparam int MINUTE = CPS * IWT_SECONDS_PER_MINUTE;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, expiry_output_n, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] fireReq, srcLevel;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int n;

    iwt_inactivity_watchdog #(.CYCLES_PER_SECOND(CPS)) i_iwt_inactivity_watchdog (.clock(clock), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .keyboard_irq_source(srcLevel[0]), .mouseIrq(srcLevel[1]),
        .serial1Irq(srcLevel[2]), .serial2Irq(srcLevel[3]), .expiry_output_n(expiry_output_n), .irq(irq));
    iwt_event_source i_iwt_event_source (.clock(clock), .rst_n(rst_n), .fireReq(fireReq), .srcLevel(srcLevel));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Master waits for pready with no assumed latency; the cycle ceiling ends a hang
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask

    // Arms a one-minute countdown, fires one source two thirds in, then looks past the first expiry point
    task automatic run_case(input logic [31:0] mask, input int src, input logic exp);
        wr(IWT_ADDR_MASK, mask);
        wr(IWT_ADDR_TIMEOUT, 32'h01);
        tick(MINUTE * 2 / 3);
        fireReq <= 4'h1 << src;
        tick(1);
        fireReq <= 4'h0;
        tick(MINUTE * 3 / 4);
        chk("expiry_output_n", {31'h0, exp}, {31'h0, expiry_output_n});
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        fireReq = 4'h0;
        tick(16);
        rst_n <= 1'b1;
        rdchk("timeout", IWT_ADDR_TIMEOUT, 32'h00);
        rdchk("mask", IWT_ADDR_MASK, 32'h00);
        rdchk("state", IWT_ADDR_STATE, 32'h01);
        wr(IWT_ADDR_MASK, 32'hff);
        rdchk("mask", IWT_ADDR_MASK, 32'h0f);
        apb(12'h00c, 1'b0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
        wr(IWT_ADDR_STATE, 32'h80);
        rdchk("state", IWT_ADDR_STATE, 32'h81);
        wr(IWT_ADDR_STATE, 32'h84);
        rdchk("state", IWT_ADDR_STATE, 32'h85);
        wr(IWT_ADDR_MASK, 32'h00);
        wr(IWT_ADDR_TIMEOUT, 32'h01);
        rdchk("state", IWT_ADDR_STATE, 32'h85);
        chk("expiry_output_n", 32'h1, {31'h0, expiry_output_n});
        n = 0;
        while (expiry_output_n !== 1'b0 && n < 2 * MINUTE) begin
            @(posedge clock);
            n++;
        end
        chk("expiry_time", 32'h1, 32'(n >= CPS - 6 && n <= CPS + 4));
        rdchk("state", IWT_ADDR_STATE, 32'h84);
        chk("irq", 32'h0, {31'h0, irq});
        rdchk("irq_status", IWT_ADDR_IRQ_STATUS, 32'h01);
        tick(MINUTE + 100);
        chk("expiry_output_n", 32'h0, {31'h0, expiry_output_n});
        wr(IWT_ADDR_TIMEOUT, 32'h00);
        tick(1);
        chk("expiry_output_n", 32'h1, {31'h0, expiry_output_n});
        rdchk("state", IWT_ADDR_STATE, 32'h85);
        tick(MINUTE + 100);
        chk("expiry_output_n", 32'h1, {31'h0, expiry_output_n});
        wr(IWT_ADDR_STATE, 32'h00);
        wr(IWT_ADDR_TIMEOUT, 32'h01);
        rdchk("state", IWT_ADDR_STATE, 32'h01);
        wr(IWT_ADDR_IRQ_STATUS, 32'h03);
        wr(IWT_ADDR_IRQ_MASK, 32'h01);
        for (int i = 0; i < IWT_NUM_SOURCES; i++) begin
            run_case(32'h1 << i, i, 1'b1);
            rdchk("irq_status", IWT_ADDR_IRQ_STATUS, 32'h02);
            run_case(~(32'h1 << i) & 32'h0f, i, 1'b0);
            chk("irq", 32'h1, {31'h0, irq});
            wr(IWT_ADDR_TIMEOUT, 32'h00);
            wr(IWT_ADDR_IRQ_STATUS, 32'h03);
            tick(2);
            chk("irq", 32'h0, {31'h0, irq});
        end
        tally_and_finish();
    end
endmodule

bind iwt_inactivity_watchdog iwt_watchdog_props i_iwt_watchdog_props (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .expiry_output_n(expiry_output_n), .irq(irq));
`default_nettype wire

// *** src/iwt_inactivity_watchdog.sv ***
// Summary of operation
// - While counting, an enabled trigger source reloads the counter from the timeout value and restarts the countdown.
// - Mask bit 0 enables the keyboard interrupt as a trigger event.
// - Mask bit 1 enables the mouse interrupt as a trigger event.
// - Mask bit 2 enables the first serial port interrupt as a trigger event.
// - Mask bit 3 enables the second serial port interrupt as a trigger event.
// - The state register reads 01h after reset; activation sets bit 0 and leaves the unit bits unchanged.
// - State bit 0 always mirrors the expiry signal, 0 expired and 1 inactive.
// - Writing 80h to the state register sets time-unit bit 7.
// - Writing 84h then sets time-unit bit 2, and seconds are counted while bits 7 and 2 are both 1.
// - State bit 0 falls when the count reaches zero and stays low until a timeout write or reset.
// - A timeout write loads the counter and starts or restarts the countdown.
// - Any timeout write releases the expiry output, and a zero value deactivates the timer.
// - At zero the counter stops, the expiry output goes low and state bit 0 clears.
// - The interrupt output stays active while an enabled interrupt status bit is set, until it is written one to clear.
`timescale 1ns/100ps
`default_nettype none
module iwt_inactivity_watchdog
    import iwt_pkg::*;
#(
    parameter int CYCLES_PER_SECOND = int'(IWT_CYCLES_PER_SECOND)
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic keyboard_irq_source,
    input wire logic mouseIrq,
    input wire logic serial1Irq,
    input wire logic serial2Irq,
    output logic expiry_output_n,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Trigger sources: two-flop synchronisers
    logic [IWT_NUM_SOURCES-1:0] rawSources;
    logic [IWT_NUM_SOURCES-1:0] syncStage1;
    logic [IWT_NUM_SOURCES-1:0] syncStage2;

    assign rawSources = {serial2Irq, serial1Irq, mouseIrq, keyboard_irq_source};

    genvar gi;
    generate
        for (gi = 0; gi < IWT_NUM_SOURCES; gi++) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    syncStage1[gi] <= 1'b0;
                    syncStage2[gi] <= 1'b0;
                end else begin
                    syncStage1[gi] <= rawSources[gi];
                    syncStage2[gi] <= syncStage1[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] timeout_reload_value;
    logic [3:0] trigger_event_mask;
    logic timeUnitHi;
    logic timeUnitLo;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [7:0] counter;
    logic expired;
    iwt_state_t state;

    logic [7:0] next_timeout_reload_value;
    logic [3:0] next_trigger_event_mask;
    logic next_timeUnitHi;
    logic next_timeUnitLo;
    logic [1:0] next_irqStatus;
    logic [1:0] next_irqMask;
    logic [7:0] next_counter;
    logic next_expired;
    iwt_state_t next_state;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_expiry_output_n;
    logic next_irq;

    logic secondTick;
    logic minuteTick;
    logic unitTick;
    logic triggerEvent;
    logic busAccess;
    logic busWrite;
    logic timeoutWrite;
    logic prescalerRestart;
    logic mapped;
    logic [7:0] expiry_state;
    logic [1:0] irqEvents;

    ////////////////////////////////////////////////////////////////////////////
    // Time base
    iwt_prescaler #(
        .CYCLES_PER_SECOND(CYCLES_PER_SECOND),
        .SECONDS_PER_MINUTE(IWT_SECONDS_PER_MINUTE)
    ) u_prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .restart(prescalerRestart),
        .secondTick(secondTick),
        .minuteTick(minuteTick)
    );

    // Seconds only once both unit bits are set, as the two-step write leaves them
    assign unitTick = (timeUnitHi && timeUnitLo) ? secondTick : minuteTick;

    // Each mask bit gates its own source
    assign triggerEvent = |(syncStage2 & trigger_event_mask);

    // A trigger restarts the whole unit, else a reload just before a tick would still expire early
    assign prescalerRestart = timeoutWrite || (triggerEvent && (state == IWT_COUNTING));

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; one-wait-state slave, pready registered one cycle into the access phase
    assign busAccess = psel && penable && !pready;
    assign busWrite = busAccess && pwrite;
    assign timeoutWrite = busWrite && (paddr == IWT_ADDR_TIMEOUT);
    assign mapped = (paddr == IWT_ADDR_TIMEOUT) || (paddr == IWT_ADDR_MASK) ||
                    (paddr == IWT_ADDR_STATE) || (paddr == IWT_ADDR_IRQ_STATUS) ||
                    (paddr == IWT_ADDR_IRQ_MASK);

    always_comb begin
        expiry_state = 8'h0;
        expiry_state[IWT_STATE_UNIT_HI_BIT] = timeUnitHi;
        expiry_state[IWT_STATE_UNIT_LO_BIT] = timeUnitLo;
        expiry_state[IWT_STATE_EXPIRY_BIT] = !expired;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_timeout_reload_value = timeout_reload_value;
        next_trigger_event_mask = trigger_event_mask;
        next_timeUnitHi = timeUnitHi;
        next_timeUnitLo = timeUnitLo;
        next_irqMask = irqMask;
        next_counter = counter;
        next_expired = expired;
        next_state = state;
        next_prdata = 32'h0;
        next_pready = busAccess;
        next_pslverr = busAccess && !mapped;
        irqEvents = 2'h0;

        case (state)
            IWT_IDLE: begin
                next_expired = expired;
            end
            IWT_COUNTING: begin
                if (triggerEvent) begin
                    next_counter = timeout_reload_value;
                end else if (unitTick) begin
                    if (counter == 8'h1) begin
                        next_counter = 8'h0;
                        next_expired = 1'b1;
                        next_state = IWT_IDLE;
                        irqEvents[IWT_IRQ_EXPIRED_BIT] = 1'b1;
                    end else begin
                        next_counter = counter - 8'h1;
                    end
                end
                if (triggerEvent) begin
                    irqEvents[IWT_IRQ_TRIGGER_BIT] = 1'b1;
                end
            end
            default: begin
                next_state = IWT_IDLE;
            end
        endcase

        if (busWrite) begin
            case (paddr)
                IWT_ADDR_TIMEOUT: begin
                    next_timeout_reload_value = pwdata[7:0];
                    next_counter = pwdata[7:0];
                    next_expired = 1'b0;
                    // Activation sets the expiry bit; unit bits survive so seconds can be chosen first
                    if (pwdata[7:0] != 8'h0) begin
                        next_state = IWT_COUNTING;
                    end else begin
                        next_state = IWT_IDLE;
                    end
                end
                IWT_ADDR_MASK: begin
                    next_trigger_event_mask = pwdata[3:0];
                end
                IWT_ADDR_STATE: begin
                    // Unit bits are writable although the register reads as status
                    next_timeUnitHi = pwdata[IWT_STATE_UNIT_HI_BIT];
                    next_timeUnitLo = pwdata[IWT_STATE_UNIT_LO_BIT];
                end
                IWT_ADDR_IRQ_MASK: begin
                    next_irqMask = pwdata[1:0];
                end
                default: begin
                    next_irqMask = irqMask;
                end
            endcase
        end

        if (busAccess && !pwrite) begin
            case (paddr)
                IWT_ADDR_TIMEOUT: next_prdata = {24'h0, timeout_reload_value};
                IWT_ADDR_MASK: next_prdata = {28'h0, trigger_event_mask};
                IWT_ADDR_STATE: next_prdata = {24'h0, expiry_state};
                IWT_ADDR_IRQ_STATUS: next_prdata = {30'h0, irqStatus};
                IWT_ADDR_IRQ_MASK: next_prdata = {30'h0, irqMask};
                default: next_prdata = 32'h0;
            endcase
        end

        // New events win over a simultaneous write-one-to-clear
        next_irqStatus = irqStatus;
        if (busWrite && paddr == IWT_ADDR_IRQ_STATUS) begin
            next_irqStatus = irqStatus & ~pwdata[1:0];
        end
        next_irqStatus = next_irqStatus | irqEvents;

        next_expiry_output_n = !next_expired;
        // Status bits are sticky until written one to clear, so the line holds until software clears them
        next_irq = |(next_irqStatus & next_irqMask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timeout_reload_value <= IWT_TIMEOUT_RESET;
            trigger_event_mask <= IWT_MASK_RESET;
            timeUnitHi <= IWT_STATE_RESET[IWT_STATE_UNIT_HI_BIT];
            timeUnitLo <= IWT_STATE_RESET[IWT_STATE_UNIT_LO_BIT];
            irqStatus <= IWT_IRQ_RESET;
            irqMask <= IWT_IRQ_RESET;
            counter <= IWT_TIMEOUT_RESET;
            expired <= !IWT_STATE_RESET[IWT_STATE_EXPIRY_BIT];
            state <= IWT_IDLE;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            expiry_output_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            timeout_reload_value <= next_timeout_reload_value;
            trigger_event_mask <= next_trigger_event_mask;
            timeUnitHi <= next_timeUnitHi;
            timeUnitLo <= next_timeUnitLo;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            counter <= next_counter;
            expired <= next_expired;
            state <= next_state;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            expiry_output_n <= next_expiry_output_n;
            irq <= next_irq;
        end
    end
endmodule
`default_nettype wire

// *** src/iwt_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none
module iwt_prescaler
    import iwt_pkg::*;
#(
    parameter int CYCLES_PER_SECOND = int'(IWT_CYCLES_PER_SECOND),
    parameter int SECONDS_PER_MINUTE = IWT_SECONDS_PER_MINUTE
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic restart,
    output logic secondTick,
    output logic minuteTick
);
    logic [31:0] cycleCount;
    logic [7:0] secondCount;
    logic [31:0] next_cycleCount;
    logic [7:0] next_secondCount;
    logic next_secondTick;
    logic next_minuteTick;

    // Restart aligns the first tick a full unit after a timeout write
    always_comb begin
        next_cycleCount = cycleCount + 32'h1;
        next_secondCount = secondCount;
        next_secondTick = 1'b0;
        next_minuteTick = 1'b0;
        if (restart) begin
            next_cycleCount = 32'h0;
            next_secondCount = 8'h0;
        end else if (cycleCount == 32'(CYCLES_PER_SECOND - 1)) begin
            next_cycleCount = 32'h0;
            next_secondTick = 1'b1;
            if (secondCount == 8'(SECONDS_PER_MINUTE - 1)) begin
                next_secondCount = 8'h0;
                next_minuteTick = 1'b1;
            end else begin
                next_secondCount = secondCount + 8'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cycleCount <= 32'h0;
            secondCount <= 8'h0;
            secondTick <= 1'b0;
            minuteTick <= 1'b0;
        end else begin
            cycleCount <= next_cycleCount;
            secondCount <= next_secondCount;
            secondTick <= next_secondTick;
            minuteTick <= next_minuteTick;
        end
    end
endmodule
`default_nettype wire
